// ---- design/smf_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Nonce reply carries eight random bytes
// [R2] Payload protected by external AES-128 keystream
// [R3] Nonce-requesting frame also requests next nonce
// [R4] Receiver discards frames after nonce expiry
// [R5] IV holds internal nonce; key uses both
// [R6] Frame byte order class header IV ctrl
// [R7] Control byte field positions fixed
// [R8] Reserved control bits sent zero, ignored
// [R9] Sequenced flag set only when split
// [R10] First split frame uses nonce-requesting variant
// [R11] Class and command bytes only first frame
// [R12] Sequenced and second flags decode frame
// [R13] Receiver pairs sender id with counter
// [R14] Counter advances per new split command
// [R15] Payload class, command, then parameters
// [R16] Nonce identifier byte follows payload
// [R17] Receiver checks eight-byte authentication code
// [R18] Receiver nonce timer three to twenty seconds
// [R19] Each nonce used for one frame only
// [R20] Receiver timer starts at reply transmission
// [R21] Sequence counter wraps modulo sixteen
module smf_framer
  import smf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Parameter memory write
  input wire logic i_param_wr,
  input wire logic [4:0] i_param_addr,
  input wire logic [7:0] i_param_byte,
  // Command request
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_class,
  input wire logic [7:0] i_cmd_id,
  input wire logic i_cmd_split,
  input wire logic i_cmd_stream,
  input wire logic [5:0] i_len_first,
  input wire logic [5:0] i_len_second,
  output logic o_busy,
  output logic o_done,
  // Cipher engine
  input wire logic [7:0] i_ks_byte,
  input wire logic [63:0] i_mac,
  input wire logic i_mac_valid,
  output logic [63:0] o_ext_nonce,
  output logic [63:0] o_int_nonce,
  output logic [6:0] o_cipher_idx,
  // Transmit byte stream
  input wire logic i_tx_ready,
  output logic [7:0] o_tx_byte,
  output logic o_tx_valid,
  output logic o_tx_last,
  // Receive byte stream
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_rx_last,
  // Status
  output logic o_nonce_valid,
  output logic [3:0] o_seq_cnt
);
  logic [7:0] params [SMF_PARAM_DEPTH];
  logic [63:0] rand_word;
  smf_state_t state, next_state;
  logic [3:0] idx, next_idx;
  logic [6:0] pay_pos, next_pay_pos;
  logic [4:0] pptr, next_pptr;
  logic [7:0] cls, next_cls, cid, next_cid;
  logic split, next_split, stream, next_stream, second, next_second;
  logic [5:0] len1, next_len1, len2, next_len2;
  logic [3:0] seq, next_seq;
  logic [63:0] ext_n, next_ext_n, int_n, next_int_n, rpl_n, next_rpl_n;
  logic nvalid, next_nvalid, rpl_pend, next_rpl_pend;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [7:0] rx_hdr, next_rx_hdr;
  logic [7:0] tx_byte, next_tx_byte;
  logic tx_valid, next_tx_valid, tx_last, next_tx_last, done, next_done, busy, next_busy;
  logic load, emit, fin, rpt_set, get_set;
  logic [7:0] ebyte, plain;
  logic [6:0] flen;
  smf_prng u_prng (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_rand(rand_word)
  );
  // ----------------------------------------
  // Parameter memory
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_param_wr) begin
      params[i_param_addr] <= i_param_byte;
    end
  end
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_seq = seq;
    {next_idx, next_pay_pos, next_pptr, next_cls, next_cid} = {idx, pay_pos, pptr, cls, cid};
    {next_split, next_stream, next_second, next_len1, next_len2} = {split, stream, second, len1, len2};
    {next_ext_n, next_int_n, next_rpl_n} = {ext_n, int_n, rpl_n};
    {next_nvalid, next_rpl_pend, next_rx_cnt, next_rx_hdr} = {nvalid, rpl_pend, rx_cnt, rx_hdr};
    {next_tx_byte, next_tx_valid, next_tx_last} = {tx_byte, tx_valid, tx_last};
    next_done = 1'b0;
    load = !tx_valid || i_tx_ready;
    emit = 1'b0;
    fin = 1'b0;
    ebyte = 8'h0_0;
    flen = second ? {1'b0, len2} : 7'(len1) + 7'h2;  // [R11]
    plain = (second || pay_pos >= 7'h0_2) ? params[pptr] : (pay_pos == 7'h0_0 ? cls : cid);  // [R15]
    rpt_set = i_rx_valid && i_rx_last && rx_cnt == 4'(SMF_RX_REPORT_LEN - 4'h1) && rx_hdr == SMF_HDR_NONCE_REPORT;
    get_set = i_rx_valid && i_rx_last && rx_cnt == 4'h1 && i_rx_byte == SMF_HDR_NONCE_GET;
    // Receive side: nonce reports and nonce requests
    if (i_rx_valid) begin
      next_rx_cnt = i_rx_last ? 4'h0 : 4'(rx_cnt + 4'h1);
      if (rx_cnt == 4'h1) next_rx_hdr = i_rx_byte;
      if (rx_hdr == SMF_HDR_NONCE_REPORT && rx_cnt >= 4'h2 && rx_cnt < SMF_RX_REPORT_LEN) begin
        next_ext_n = {ext_n[55:0], i_rx_byte};  // [R1]
      end
      if (rpt_set) next_nvalid = 1'b1;
      if (get_set) next_rpl_pend = 1'b1;
    end
    unique case (state)
      SMF_S_IDLE: begin
        if (rpl_pend) begin
          next_state = SMF_S_RPL_CLS;
          next_rpl_n = rand_word;  // [R1]
        end else if (i_cmd_valid) begin
          next_cls = i_cmd_class;
          next_cid = i_cmd_id;
          next_split = i_cmd_split;
          next_stream = i_cmd_stream;
          next_len1 = i_len_first;
          next_len2 = i_len_second;
          next_second = 1'b0;
          next_pptr = 5'h0_0;
          next_seq = i_cmd_split ? 4'(seq + 4'h1) : seq;  // [R14] [R21]
          next_state = nvalid ? SMF_S_CLS : SMF_S_GET_CLS;
        end
      end
      SMF_S_GET_CLS: begin
        emit = 1'b1;
        ebyte = SMF_CLASS_SECURE;
        if (load) next_state = SMF_S_GET_HDR;
      end
      SMF_S_GET_HDR: begin
        emit = 1'b1;
        fin = 1'b1;
        ebyte = SMF_HDR_NONCE_GET;
        if (load) next_state = SMF_S_WAIT;
      end
      SMF_S_WAIT: begin
        if (nvalid) begin
          next_state = SMF_S_CLS;
        end else if (rpl_pend) begin
          next_state = SMF_S_RPL_CLS;
          next_rpl_n = rand_word;
        end
      end
      SMF_S_CLS: begin
        emit = 1'b1;
        ebyte = SMF_CLASS_SECURE;  // [R6]
        next_int_n = rand_word;  // [R5]
        next_idx = 4'h0;
        next_pay_pos = 7'h0_0;
        if (load) next_state = SMF_S_HDR;
      end
      SMF_S_HDR: begin
        emit = 1'b1;
        // First of two always requests, second or single only when streaming
        ebyte = ((split && !second) || stream) ? SMF_HDR_SEALED_NG : SMF_HDR_SEALED;  // [R3] [R10]
        if (load) next_state = SMF_S_IV;
      end
      SMF_S_IV: begin
        emit = 1'b1;
        ebyte = int_n[8'(63 - 8 * idx) -: 8];  // [R5]
        if (load) begin
          next_idx = 4'(idx + 4'h1);
          if (idx == 4'(SMF_NONCE_BYTES - 4'h1)) next_state = SMF_S_CTRL;
        end
      end
      SMF_S_CTRL: begin
        emit = 1'b1;
        ebyte = {SMF_CTRL_RSVD_VAL, second, split, seq};  // [R7] [R8] [R9] [R12]
        if (load) next_state = SMF_S_PAY;
      end
      SMF_S_PAY: begin
        if (pay_pos >= flen) begin
          next_state = SMF_S_NID;
        end else begin
          emit = 1'b1;
          ebyte = plain ^ i_ks_byte;  // [R2] [R5]
          if (load) begin
            next_pay_pos = 7'(pay_pos + 7'h1);
            if (second || pay_pos >= 7'h2) next_pptr = 5'(pptr + 5'h1);
          end
        end
      end
      SMF_S_NID: begin
        emit = 1'b1;
        ebyte = ext_n[63:56];  // [R16]
        next_idx = 4'h0;
        if (load) next_state = SMF_S_MAC;
      end
      SMF_S_MAC: begin
        if (i_mac_valid) begin
          emit = 1'b1;
          fin = idx == 4'(SMF_MAC_BYTES - 4'h1);
          ebyte = i_mac[8'(63 - 8 * idx) -: 8];  // [R6]
          if (load) begin
            next_idx = 4'(idx + 4'h1);
            if (fin) begin
              next_nvalid = rpt_set;  // [R19]
              if (split && !second) begin
                next_second = 1'b1;
                next_state = SMF_S_WAIT;  // [R3]
              end else begin
                next_done = 1'b1;
                next_state = SMF_S_IDLE;
              end
            end
          end
        end
      end
      SMF_S_RPL_CLS: begin
        emit = 1'b1;
        ebyte = SMF_CLASS_SECURE;
        next_idx = 4'h0;
        if (load) next_state = SMF_S_RPL_HDR;
      end
      SMF_S_RPL_HDR: begin
        emit = 1'b1;
        ebyte = SMF_HDR_NONCE_REPORT;
        if (load) next_state = SMF_S_RPL_NONCE;
      end
      SMF_S_RPL_NONCE: begin
        emit = 1'b1;
        fin = idx == 4'(SMF_NONCE_BYTES - 4'h1);
        ebyte = rpl_n[8'(63 - 8 * idx) -: 8];  // [R1]
        if (load) begin
          next_idx = 4'(idx + 4'h1);
          if (fin) begin
            next_rpl_pend = get_set;
            next_state = (cls == 8'h0_0 && !split) || !second ? SMF_S_IDLE : SMF_S_WAIT;
          end
        end
      end
      default: next_state = SMF_S_IDLE;
    endcase
    if (load) begin
      next_tx_valid = emit;
      next_tx_byte = emit ? ebyte : tx_byte;
      next_tx_last = emit && fin;
    end
    next_busy = next_state != SMF_S_IDLE;
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SMF_S_IDLE;
      seq <= SMF_SEQ_RESET;
      {idx, pay_pos, pptr, cls, cid, split, stream, second, len1, len2} <= '0;
      {ext_n, int_n, rpl_n, nvalid, rpl_pend, rx_cnt, rx_hdr} <= '0;
      {tx_byte, tx_valid, tx_last, done, busy} <= '0;
    end else begin
      state <= next_state;
      seq <= next_seq;
      {idx, pay_pos, pptr, cls, cid} <= {next_idx, next_pay_pos, next_pptr, next_cls, next_cid};
      {split, stream, second, len1, len2} <= {next_split, next_stream, next_second, next_len1, next_len2};
      {ext_n, int_n, rpl_n} <= {next_ext_n, next_int_n, next_rpl_n};
      {nvalid, rpl_pend, rx_cnt, rx_hdr} <= {next_nvalid, next_rpl_pend, next_rx_cnt, next_rx_hdr};
      {tx_byte, tx_valid, tx_last, done, busy} <= {next_tx_byte, next_tx_valid, next_tx_last, next_done, next_busy};
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_busy = busy;
  assign o_done = done;
  assign o_ext_nonce = ext_n;
  assign o_int_nonce = int_n;
  assign o_cipher_idx = pay_pos;
  assign o_tx_byte = tx_byte;
  assign o_tx_valid = tx_valid;
  assign o_tx_last = tx_last;
  assign o_nonce_valid = nvalid;
  assign o_seq_cnt = seq;
endmodule
`default_nettype wire

// ---- design/smf_pkg.sv ----
package smf_pkg;
  // ----------------------------------------
  // Frame codes
  // ----------------------------------------
  localparam logic [7:0] SMF_CLASS_SECURE = 8'h0_1;
  localparam logic [7:0] SMF_HDR_NONCE_GET = 8'h0_2;
  localparam logic [7:0] SMF_HDR_NONCE_REPORT = 8'h0_3;
  localparam logic [7:0] SMF_HDR_SEALED = 8'h0_4;
  localparam logic [7:0] SMF_HDR_SEALED_NG = 8'h0_5;
  // ----------------------------------------
  // Control byte layout
  // ----------------------------------------
  localparam int SMF_CTRL_SECOND_BIT = 5;
  localparam int SMF_CTRL_SEQ_BIT = 4;
  localparam int SMF_CTRL_CNT_MSB = 3;
  localparam logic [1:0] SMF_CTRL_RSVD_VAL = 2'h0;
  localparam logic [3:0] SMF_SEQ_RESET = 4'h0;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam logic [3:0] SMF_NONCE_BYTES = 4'h8;
  localparam logic [3:0] SMF_MAC_BYTES = 4'h8;
  localparam logic [3:0] SMF_RX_REPORT_LEN = 4'hA;
  localparam int SMF_PARAM_DEPTH = 32;
  localparam logic [63:0] SMF_PRNG_SEED = 64'h0123_4567_89AB_CDEF;

  typedef enum logic [3:0] {
    SMF_S_IDLE = 4'b0000,
    SMF_S_GET_CLS = 4'b0001,
    SMF_S_GET_HDR = 4'b0010,
    SMF_S_WAIT = 4'b0011,
    SMF_S_CLS = 4'b0100,
    SMF_S_HDR = 4'b0101,
    SMF_S_IV = 4'b0110,
    SMF_S_CTRL = 4'b0111,
    SMF_S_PAY = 4'b1000,
    SMF_S_NID = 4'b1001,
    SMF_S_MAC = 4'b1010,
    SMF_S_RPL_CLS = 4'b1011,
    SMF_S_RPL_HDR = 4'b1100,
    SMF_S_RPL_NONCE = 4'b1101
  } smf_state_t;
endpackage

// ---- design/smf_prng.sv ----
`timescale 1ns/1ps
`default_nettype none
module smf_prng
  import smf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Random word
  output logic [63:0] o_rand
);
  logic [63:0] state;
  logic [63:0] next_state;
  logic [63:0] t1;
  logic [63:0] t2;

  // ----------------------------------------
  // Xorshift step every cycle
  // ----------------------------------------
  always_comb begin
    t1 = state ^ (state << 13);
    t2 = t1 ^ (t1 >> 7);
    next_state = t2 ^ (t2 << 17);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SMF_PRNG_SEED;
    end else begin
      state <= next_state;
    end
  end

  assign o_rand = state;
endmodule
`default_nettype wire

// ---- testbench/smf_framer_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module smf_checker
  import smf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Streams
  input wire logic i_tx_ready,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_rx_last,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_tx_valid,
  input wire logic o_tx_last,
  // Status
  input wire logic o_done,
  input wire logic o_nonce_valid,
  input wire logic [63:0] o_int_nonce,
  input wire logic [3:0] o_seq_cnt
);
  logic [5:0] pos;
  logic [3:0] rpos;
  logic [7:0] hdr;
  logic [7:0] rhdr;
  logic acc;
  logic sealed;
  assign acc = o_tx_valid && i_tx_ready;
  assign sealed = hdr == SMF_HDR_SEALED || hdr == SMF_HDR_SEALED_NG;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos <= 6'h0;
      rpos <= 4'h0;
      hdr <= 8'h0;
      rhdr <= 8'h0;
    end else begin
      if (acc) begin
        pos <= o_tx_last ? 6'h0 : pos + 6'h1;
      end
      if (acc && pos == 6'h1) begin
        hdr <= o_tx_byte;
      end
      if (i_rx_valid) begin
        rpos <= i_rx_last ? 4'h0 : rpos + 4'h1;
      end
      if (i_rx_valid && rpos == 4'h1) begin
        rhdr <= i_rx_byte;
      end
    end
  end
  sequence s_ctrl;
    acc && sealed && pos == 6'hA;
  endsequence
  sequence s_report;
    i_rx_valid && i_rx_last && rpos == 4'h9 && rhdr == SMF_HDR_NONCE_REPORT;
  endsequence
  a_tx_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last)) else $error("tx hold");
  a_class_first: assert property (@(posedge i_clk) disable iff (!i_rstn)
    acc && pos == 6'h0 |-> o_tx_byte == SMF_CLASS_SECURE) else $error("class byte");
  a_iv_nonce: assert property (@(posedge i_clk) disable iff (!i_rstn)
    acc && sealed && pos >= 6'h2 && pos <= 6'h9 |-> o_tx_byte == o_int_nonce[8*(9-pos) +: 8]) else $error("iv");
  a_ctrl_rsvd: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_ctrl |-> o_tx_byte[7:6] == SMF_CTRL_RSVD_VAL) else $error("reserved bits");
  a_ctrl_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_ctrl |-> o_tx_byte[3:0] == o_seq_cnt) else $error("ctrl counter");
  a_ctrl_combo: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_ctrl |-> !(o_tx_byte[5] && !o_tx_byte[4])) else $error("flag combination");
  a_seq_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_seq_cnt != $past(o_seq_cnt) |-> o_seq_cnt == $past(o_seq_cnt) + 4'h1) else $error("seq step");
  a_nonce_once: assert property (@(posedge i_clk) disable iff (!i_rstn)
    acc && o_tx_last && sealed |=> !o_nonce_valid) else $error("nonce reused");
  a_report_sets: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_report |=> o_nonce_valid) else $error("nonce not held");
  a_done_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_done |-> o_tx_valid && o_tx_last) else $error("done");
endmodule
bind smf_framer smf_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_ready(i_tx_ready),
  .i_rx_byte(i_rx_byte), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last), .o_tx_byte(o_tx_byte),
  .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last), .o_done(o_done), .o_nonce_valid(o_nonce_valid),
  .o_int_nonce(o_int_nonce), .o_seq_cnt(o_seq_cnt));
`default_nettype wire

// ---- testbench/smf_framer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module smf_framer_tb_top
  import smf_pkg::*;
;
  localparam logic [7:0] CLS = 8'h71;
  localparam logic [7:0] CID = 8'h2C;
  localparam logic [63:0] MAC = 64'h1122_3344_5566_7788;
  localparam int TMO = 2000;
  logic i_clk = 0, i_rstn = 0, i_param_wr = 0, i_cmd_valid = 0, i_cmd_split = 0, i_cmd_stream = 0;
  logic i_mac_valid = 1, i_stall = 0, slow = 0, i_tx_ready, i_rx_valid, i_rx_last;
  logic o_busy, o_done, o_tx_valid, o_tx_last, o_nonce_valid;
  logic [4:0] i_param_addr = 0;
  logic [5:0] i_len_first = 0, i_len_second = 0;
  logic [6:0] o_cipher_idx;
  logic [7:0] i_param_byte = 0, i_ks_byte, o_tx_byte, i_rx_byte;
  logic [3:0] o_seq_cnt, sq = 0;
  logic [63:0] o_ext_nonce, o_int_nonce;
  logic [63:0] rn [0:1];
  int mismatches = 0, check_count = 0, cyc = 0;
  smf_framer smf_framer_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_param_wr(i_param_wr),
    .i_param_addr(i_param_addr), .i_param_byte(i_param_byte), .i_cmd_valid(i_cmd_valid), .i_cmd_class(CLS),
    .i_cmd_id(CID), .i_cmd_split(i_cmd_split), .i_cmd_stream(i_cmd_stream), .i_len_first(i_len_first),
    .i_len_second(i_len_second), .o_busy(o_busy), .o_done(o_done), .i_ks_byte(i_ks_byte), .i_mac(MAC),
    .i_mac_valid(i_mac_valid), .o_ext_nonce(o_ext_nonce), .o_int_nonce(o_int_nonce),
    .o_cipher_idx(o_cipher_idx), .i_tx_ready(i_tx_ready), .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid),
    .o_tx_last(o_tx_last), .i_rx_byte(i_rx_byte), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last),
    .o_nonce_valid(o_nonce_valid), .o_seq_cnt(o_seq_cnt));
  smf_peer #(.TMO(TMO), .MAC(MAC)) pr (.i_clk(i_clk), .i_stall(i_stall), .i_tx_byte(o_tx_byte),
    .i_tx_valid(o_tx_valid), .i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready), .o_rx_byte(i_rx_byte),
    .o_rx_valid(i_rx_valid), .o_rx_last(i_rx_last));
  function automatic logic [7:0] ks(input logic [6:0] k);
    return {1'b0, k} ^ 8'h5A;
  endfunction
  function automatic logic [7:0] pv(input int a);
    return 8'(a) ^ 8'hC3;
  endfunction
  function automatic logic [7:0] hb(input int k);
    return pr.mem[pr.fst[k]+1];
  endfunction
  assign i_ks_byte = ks(o_cipher_idx);
  initial forever #10 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    i_stall <= slow && cyc % 3 == 0;
    i_mac_valid <= !slow || cyc % 4 == 0;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic sp, input logic st, input logic [5:0] l1, input logic [5:0] l2);
    int w;
    @(negedge i_clk);
    i_cmd_valid = 1;
    i_cmd_split = sp;
    i_cmd_stream = st;
    i_len_first = l1;
    i_len_second = l2;
    @(negedge i_clk);
    i_cmd_valid = 0;
    chk(8'(o_busy), 8'h1);
    w = 0;
    while (o_done !== 1'b1 && w < 3000) begin @(negedge i_clk); w++; end
    chk(8'(o_busy), 8'h0);
    while (o_tx_valid !== 1'b0 && w < 3000) begin @(negedge i_clk); w++; end
    while (st && o_nonce_valid !== 1'b1 && w < 3000) begin @(negedge i_clk); w++; end
    chk(8'(w < 3000), 8'h1);
  endtask
  task automatic frame(input int k, input logic [7:0] hdr, input logic [7:0] ctl, input int off, input int pl);
    int b;
    logic [7:0] e;
    b = pr.fst[k];
    chk(8'(pr.fst[k+1] - b), 8'(20 + pl));
    chk(hb(k), hdr);
    chk(pr.mem[b+10], ctl);
    for (int i = 0; i < pl; i++) begin
      e = off < 0 ? (i == 0 ? CLS : i == 1 ? CID : pv(i - 2)) : pv(off + i);
      chk(pr.mem[b+11+i] ^ ks(7'(i)), e);
    end
  endtask
  task automatic t_reply();
    int f;
    int w;
    for (int j = 0; j < 2; j++) begin
      f = pr.nf;
      pr.send(2, {SMF_CLASS_SECURE, SMF_HDR_NONCE_GET, 64'h0});
      w = 0;
      while (pr.nf == f && w < 200) begin @(negedge i_clk); w++; end
      chk(8'(pr.fst[f+1] - pr.fst[f]), 8'hA);
      chk(hb(f), SMF_HDR_NONCE_REPORT);
      for (int i = 0; i < 8; i++) rn[j][63-8*i -: 8] = pr.mem[pr.fst[f]+2+i];
    end
    chk(8'(rn[0] === rn[1]), 8'h0);
  endtask
  task automatic t_single();
    int f;
    f = pr.nf;
    cmd(0, 1, 3, 0);
    chk(8'(o_ext_nonce === pr.nonce), 8'h1);
    chk(8'(pr.nf - f), 8'h2);
    chk(hb(f), SMF_HDR_NONCE_GET);
    frame(f + 1, SMF_HDR_SEALED_NG, {4'h0, sq}, -1, 5);
    chk(8'(pr.drops), 8'h0);
  endtask
  task automatic t_expire();
    int f;
    f = pr.nf;
    repeat (TMO + 10) @(negedge i_clk);
    cmd(0, 0, 1, 0);
    chk(8'(pr.nf - f), 8'h1);
    frame(f, SMF_HDR_SEALED, {4'h0, sq}, -1, 3);
    chk(8'(pr.drops), 8'h1);
  endtask
  task automatic t_split();
    int f;
    f = pr.nf;
    sq = sq + 4'h1;
    slow = 1;
    cmd(1, 0, 2, 3);
    slow = 0;
    chk(8'(pr.nf - f), 8'h3);
    frame(f + 1, SMF_HDR_SEALED_NG, {4'h1, sq}, -1, 4);
    frame(f + 2, SMF_HDR_SEALED, {4'h3, sq}, 2, 3);
    chk(8'(o_seq_cnt), 8'(sq));
    chk(8'(pr.drops), 8'h1);
  endtask
  task automatic t_wrap();
    int f;
    for (int j = 0; j < 16; j++) begin
      sq = sq + 4'h1;
      f = pr.nf + (j == 0 ? 1 : 0);
      cmd(1, 1, 1, 0);
      frame(f, SMF_HDR_SEALED_NG, {4'h1, sq}, -1, 3);
      frame(f + 1, SMF_HDR_SEALED_NG, {4'h3, sq}, 1, 0);
    end
    chk(8'(pr.drops), 8'h1);
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_rstn = 1;
    for (int a = 0; a < 32; a++) begin
      i_param_wr = 1;
      i_param_addr = 5'(a);
      i_param_byte = pv(a);
      @(negedge i_clk);
    end
    i_param_wr = 0;
    t_reply();
    t_single();
    t_expire();
    t_split();
    t_wrap();
    conclude();
  end
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire

// ---- testbench/smf_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module smf_peer
  import smf_pkg::*;
#(
  parameter int DLY = 3,
  parameter int TMO = 2000,
  parameter logic [63:0] MAC = 64'h0
)
(
  // Clock and stall
  input wire logic i_clk,
  input wire logic i_stall,
  // Frames in
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_valid,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  // Frames out
  output logic [7:0] o_rx_byte = 8'h0,
  output logic o_rx_valid = 1'b0,
  output logic o_rx_last = 1'b0
);
  logic [7:0] mem [0:4095];
  int fst [0:255];
  int n = 0;
  int nf = 0;
  int age = 0;
  int drops = 0;
  logic held = 1'b0;
  logic bad;
  logic [7:0] b1;
  logic [7:0] c;
  logic [3:0] sc = 4'h0;
  logic [63:0] nonce = 64'h0BAD_F00D_1234_5678;
  event want;
  assign o_tx_ready = !i_stall;
  initial fst[0] = 0;
  task automatic send(input int len, input logic [79:0] f);
    for (int i = 0; i < len; i++) begin
      o_rx_byte <= f[79-8*i -: 8];
      o_rx_valid <= 1'b1;
      o_rx_last <= i == len - 1;
      @(posedge i_clk);
    end
    o_rx_valid <= 1'b0;
    o_rx_last <= 1'b0;
    o_rx_byte <= ~o_rx_byte;
  endtask
  always @(posedge i_clk) begin
    age = age + 1;
    if (i_tx_valid && o_tx_ready) begin
      mem[n] = i_tx_byte;
      n = n + 1;
      if (i_tx_last) begin
        b1 = mem[fst[nf]+1];
        nf = nf + 1;
        fst[nf] = n;
        if (b1 == SMF_HDR_SEALED || b1 == SMF_HDR_SEALED_NG) begin
          bad = !held || age > TMO || mem[n-9] != nonce[63:56];
          for (int i = 0; i < 8; i++) bad = bad || mem[n-8+i] != MAC[63-8*i -: 8];
          c = mem[fst[nf-1]+10];
          if (c[4] && c[5]) bad = bad || c[3:0] != sc;
          if (c[4] && !c[5]) sc = c[3:0];
          drops = drops + int'(bad);
          held = 1'b0;
        end
        if (b1 == SMF_HDR_NONCE_GET || b1 == SMF_HDR_SEALED_NG) ->want;
      end
    end
  end
  initial forever begin
    @want;
    repeat (DLY) @(posedge i_clk);
    nonce = nonce * 64'h5851_F42D_4C95_7F2D + 64'h1;
    send(10, {SMF_CLASS_SECURE, SMF_HDR_NONCE_REPORT, nonce});
    age = 0;
    held = 1'b1;
  end
endmodule
`default_nettype wire
